// ===== hdl/csb_status.v
`timescale 1ns/1ns
`include "csb_map.vh"
module csb_status (
	input wire clk_in,
	input wire arst_n_in,
	input wire [7:0] avs_address_in,
	input wire avs_read_in,
	input wire avs_write_in,
	input wire [31:0] avs_writedata_in,
	output reg [31:0] avs_readdata_out,
	output reg avs_waitrequest_out,
	input wire [1:0] chn_select_in,
	input wire [7:0] chn_drive_in,
	input wire [15:0] chn_cmd_in,
	input wire [1:0] chn_accept_in,
	input wire [1:0] chn_chain_in,
	input wire [1:0] chn_reset_in,
	output wire [15:0] chn_bus_out,
	output wire [1:0] chn_parity_out,
	output wire [1:0] chn_status_tag_out,
	output wire [1:0] chn_mark0_out,
	output wire [1:0] chn_short_busy_out,
	input wire op_start_in,
	input wire op_chan_in,
	input wire [3:0] op_drive_in,
	input wire [1:0] op_kind_in,
	input wire ctl_busy_in,
	input wire [15:0] drv_busy_in,
	input wire [15:0] drv_ready_in,
	input wire [15:0] drv_shared_in,
	input wire ev_data_done_in,
	input wire ev_ctl_accept_in,
	input wire ev_ctl_done_in,
	input wire ev_unload_done_in,
	input wire ev_marker_in,
	input wire ev_backward_start_in,
	input wire ev_file_marker_in,
	input wire ev_end_warning_in,
	input wire ev_retry_in,
	input wire [4:0] sns_index_in,
	output reg [7:0] sns_byte_out
);
	localparam P_IDLE = 3'b001;
	localparam P_SHOW = 3'b010;
	localparam P_DROP = 3'b100;
	integer i;
	reg [3:0] ctrl;
	reg [7:0] sns_mem [0:21];
	// Channel pins pass two flops; the third stage only serves edge detection.
	reg [1:0] sel_s1, sel_s2, sel_s3;
	reg [1:0] acc_s1, acc_s2, acc_s3;
	reg [1:0] chn_s1, chn_s2, rst_s1, rst_s2;
	reg [7:0] drv_s1, drv_s2;
	reg [15:0] cmd_s1, cmd_s2;
	reg op_act, op_ch, ce_done, de_done, ce_acc, ctl_q, sns_err_q;
	reg [3:0] op_drv;
	reg [1:0] op_kind;
	reg [15:0] rdy_q, bsy_q, rdy_new, busy_att, att_ch, nr_clr;
	wire [15:0] pend_w;
	wire [1:0] cue_pend, ce_taken, attach;
	wire [31:0] m_att, m_ok, m_nrc, m_nrs;
	wire dual = ctrl[`CSB_CTRL_DUAL];
	wire armed = ctrl[`CSB_CTRL_ARMED];
	wire diag = ctrl[`CSB_CTRL_DIAG];
	wire ctl_fall = ctl_q & ~ctl_busy_in;
	wire [15:0] rdy_rise = drv_ready_in & ~rdy_q;
	wire [15:0] bsy_fall = bsy_q & ~drv_busy_in;
	wire sns_err = (|sns_mem[0]) | sns_mem[1][7] | sns_mem[1][0] | sns_mem[5][4];
	wire drop = op_act & rdy_q[op_drv] & ~drv_ready_in[op_drv];
	wire ev_ce = op_act & ~ce_done & (ev_data_done_in | ev_ctl_accept_in);
	wire ev_de = op_act & ~de_done & (ev_data_done_in | ev_ctl_done_in | ev_unload_done_in
		| ev_marker_in | (drop & (op_kind != `CSB_KIND_MOTION)));
	// Event unit check is only raised while an operation is in progress.
	wire ev_uc = op_act & ((sns_err & ~sns_err_q) | ev_unload_done_in
		| ev_backward_start_in | ev_retry_in);
	wire ev_ue = op_act & ((ev_file_marker_in & (op_kind != `CSB_KIND_WRITE))
		| (ev_end_warning_in & (op_kind == `CSB_KIND_WRITE)));
	wire late_free = (ev_uc | ev_ue) & ce_acc & ctl_busy_in;
	wire [7:0] evt = {2'b00, late_free, 1'b0, ev_ce, ev_de, ev_uc, ev_ue};
	wire shared_de = |(rdy_rise & drv_shared_in);
	wire plain_de = |(rdy_rise & ~drv_shared_in) & armed;
	wire [5:0] s_word = avs_address_in[7:2] - `CSB_SENSE_WBASE;
	wire s_hit = (avs_address_in[7:2] >= `CSB_SENSE_WBASE) & (s_word < `CSB_SENSE_CNT)
		& (avs_address_in[1:0] == 2'b00);

	always @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			sel_s1 <= 2'h0;
			sel_s2 <= 2'h0;
			sel_s3 <= 2'h0;
			acc_s1 <= 2'h0;
			acc_s2 <= 2'h0;
			acc_s3 <= 2'h0;
			chn_s1 <= 2'h0;
			chn_s2 <= 2'h0;
			rst_s1 <= 2'h0;
			rst_s2 <= 2'h0;
			drv_s1 <= 8'h00;
			drv_s2 <= 8'h00;
			cmd_s1 <= 16'h0000;
			cmd_s2 <= 16'h0000;
		end else begin
			sel_s1 <= chn_select_in;
			sel_s2 <= sel_s1;
			sel_s3 <= sel_s2;
			acc_s1 <= chn_accept_in;
			acc_s2 <= acc_s1;
			acc_s3 <= acc_s2;
			chn_s1 <= chn_chain_in;
			chn_s2 <= chn_s1;
			rst_s1 <= chn_reset_in;
			rst_s2 <= rst_s1;
			drv_s1 <= chn_drive_in;
			drv_s2 <= drv_s1;
			cmd_s1 <= chn_cmd_in;
			cmd_s2 <= cmd_s1;
		end
	end

	// Operation tracking for the once-only end conditions.
	always @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			op_act <= 1'b0;
			op_ch <= 1'b0;
			op_drv <= 4'h0;
			op_kind <= 2'h0;
			ce_done <= 1'b0;
			de_done <= 1'b0;
			ce_acc <= 1'b0;
			ctl_q <= 1'b0;
			sns_err_q <= 1'b0;
		end else begin
			ctl_q <= ctl_busy_in;
			sns_err_q <= sns_err;
			if (op_start_in) begin
				op_act <= 1'b1;
				op_ch <= op_chan_in;
				op_drv <= op_drive_in;
				op_kind <= op_kind_in;
				ce_done <= 1'b0;
				de_done <= 1'b0;
				ce_acc <= 1'b0;
			end else begin
				if (ev_ce)
					ce_done <= 1'b1;
				if (ev_de) begin
					de_done <= 1'b1;
					op_act <= 1'b0;
				end
				if (|ce_taken)
					ce_acc <= 1'b1;
			end
		end
	end

	// Per-drive memory of ready edges, busy attempts and cleared not-ready.
	always @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			rdy_q <= 16'h0000;
			bsy_q <= 16'h0000;
			rdy_new <= 16'h0000;
			busy_att <= 16'h0000;
			att_ch <= 16'h0000;
			nr_clr <= 16'h0000;
		end else begin
			rdy_q <= drv_ready_in;
			bsy_q <= drv_busy_in;
			rdy_new <= (rdy_new & ~(m_ok[15:0] | m_ok[31:16])) | rdy_rise;
			busy_att <= (busy_att & ~bsy_fall) | m_att[15:0] | m_att[31:16];
			att_ch <= (att_ch & ~m_att[15:0]) | m_att[31:16];
			nr_clr <= (nr_clr & ~(m_nrc[15:0] | m_nrc[31:16] | rdy_rise))
				| m_nrs[15:0] | m_nrs[31:16];
		end
	end

	genvar g;
	generate
		for (g = 0; g < 2; g = g + 1) begin : chan
			localparam O = 1 - g;
			reg [2:0] st;
			reg [7:0] pend, pres;
			reg [3:0] pend_drv;
			reg from_pend, retry_pend, show_retry, cue_owe, tag, mark, sbusy;
			reg [7:0] bus;
			reg par;
			reg [7:0] resp;
			reg resp_v;
			wire sp = sel_s2[g] & ~sel_s3[g];
			wire ap = acc_s2[g] & ~acc_s3[g];
			wire [3:0] d = drv_s2[4*g+3:4*g];
			wire [7:0] cm = cmd_s2[8*g+7:8*g];
			wire tio = cm == `CSB_CMD_TIO;
			wire nop = cm == `CSB_CMD_NOP;
			wire idle = st == P_IDLE;
			wire mine = (pend != 8'h00) & (pend_drv == d);
			wire sb = diag | (dual & cue_pend[O]);
			wire bm = ctl_busy_in | (dual & (attach[O] | rst_s2[O])) | cue_pend[g]
				| ((pend != 8'h00) & ~mine);
			wire bd = drv_busy_in[d];
			wire nr = (tio | nop) & ~drv_ready_in[d] & (pend == 8'h00);
			wire go = sp & idle & ~sb;
			wire f_bm = go & bm;
			wire f_mine = go & ~bm & mine;
			wire f_bd = go & ~bm & ~mine & bd;
			wire f_nr = go & ~bm & ~mine & ~bd & nr;
			wire f_ok = go & ~bm & ~mine & ~bd & ~nr;
			wire own = op_ch == g;
			wire att_de = |(bsy_fall & busy_att & (g == 1 ? att_ch : ~att_ch));
			wire [7:0] st_de = (shared_de | att_de | (plain_de & (g == 0)))
				? `CSB_ST_DE : 8'h00;
			wire [7:0] st_free = ((cue_owe & ctl_fall) ? `CSB_ST_FREE : 8'h00);
			wire refused = st[1] & ap & show_retry & ~chn_s2[g] & ctrl[`CSB_CTRL_BUFFERED];
			wire [7:0] add = ((own & ~op_start_in) ? evt : 8'h00) | st_de | st_free
				| (refused ? `CSB_ST_UC : 8'h00);
			wire [7:0] clr = (st[1] & ap & from_pend) ? pres : 8'h00;
			wire [7:0] shown = (pres[4] ? pres : (pres & ~`CSB_ST_MOD)) & `CSB_ST_LEGAL;
			assign pend_w[8*g+7:8*g] = pend;
			assign cue_pend[g] = pend[5];
			assign attach[g] = op_act & own;
			assign ce_taken[g] = st[1] & ap & pres[3] & own;
			assign m_att[16*g+15:16*g] = f_bd ? (16'h0001 << d) : 16'h0000;
			assign m_ok[16*g+15:16*g] = f_ok ? (16'h0001 << d) : 16'h0000;
			assign m_nrc[16*g+15:16*g] = (f_nr & nr_clr[d]) ? (16'h0001 << d) : 16'h0000;
			assign m_nrs[16*g+15:16*g] = (f_nr & ~nr_clr[d]) ? (16'h0001 << d) : 16'h0000;
			assign chn_bus_out[8*g+7:8*g] = bus;
			assign chn_parity_out[g] = par;
			assign chn_status_tag_out[g] = tag;
			assign chn_mark0_out[g] = mark;
			assign chn_short_busy_out[g] = sbusy;

			// Initial selection answer; busy only appears here.
			always @* begin
				resp = 8'h00;
				resp_v = 1'b0;
				if (f_bm) begin
					resp = `CSB_ST_BUSY | `CSB_ST_MOD;
					resp_v = 1'b1;
				end else if (f_mine) begin
					resp = tio ? pend : (pend | `CSB_ST_BUSY);
					resp_v = 1'b1;
				end else if (f_bd) begin
					resp = `CSB_ST_BUSY;
					resp_v = 1'b1;
				end else if (f_nr) begin
					resp = nr_clr[d] ? `CSB_ST_UC : 8'h00;
					resp_v = nr_clr[d];
				end else if (f_ok & rdy_new[d] & ~armed) begin
					resp = `CSB_ST_DE;
					resp_v = 1'b1;
				end
			end

			always @(posedge clk_in or negedge arst_n_in) begin
				if (!arst_n_in) begin
					st <= P_IDLE;
					pend <= 8'h00;
					pend_drv <= 4'h0;
					pres <= 8'h00;
					from_pend <= 1'b0;
					retry_pend <= 1'b0;
					show_retry <= 1'b0;
					cue_owe <= 1'b0;
					tag <= 1'b0;
					mark <= 1'b0;
					sbusy <= 1'b0;
					bus <= 8'h00;
					par <= 1'b1;
				end else begin
					// New events win over the clear of presented bits.
					pend <= (pend & ~clr) | add;
					if (own & (evt != 8'h00))
						pend_drv <= op_drv;
					retry_pend <= (retry_pend & ~(st[1] & ap & show_retry))
						| (own & ev_retry_in & op_act);
					cue_owe <= (cue_owe & ~ctl_fall) | f_bm;
					sbusy <= sp & idle & sb;
					case (st)
						P_IDLE: begin
							if (resp_v) begin
								pres <= resp;
								from_pend <= f_mine;
								show_retry <= 1'b0;
								st <= P_SHOW;
							end else if (!sp && pend != 8'h00) begin
								pres <= pend;
								from_pend <= 1'b1;
								show_retry <= retry_pend;
								st <= P_SHOW;
							end
						end
						P_SHOW: begin
							if (ap)
								st <= P_DROP;
						end
						P_DROP: begin
							if (!acc_s2[g])
								st <= P_IDLE;
						end
						default: st <= P_IDLE;
					endcase
					tag <= st[1] & ~ap;
					mark <= st[1] & ~ap & show_retry;
					// The byte leaves the bus in the same cycle as the tag.
					bus <= (st[1] & ~ap) ? shown : 8'h00;
					par <= ~^((st[1] & ~ap) ? shown : 8'h00);
				end
			end
		end
	endgenerate

	// Register slave: one wait state, read data at the first edge, write at the second.
	always @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			ctrl <= `CSB_CTRL_RESET;
			avs_waitrequest_out <= 1'b1;
			avs_readdata_out <= 32'h00000000;
			sns_byte_out <= 8'h00;
			for (i = 0; i < 22; i = i + 1)
				sns_mem[i] <= 8'h00;
		end else begin
			sns_byte_out <= (sns_index_in < 5'd22) ? sns_mem[sns_index_in] : 8'h00;
			if (!avs_waitrequest_out) begin
				avs_waitrequest_out <= 1'b1;
				if (avs_write_in) begin
					if (avs_address_in == `CSB_REG_CTRL)
						ctrl <= avs_writedata_in[3:0];
					else if (s_hit)
						sns_mem[s_word[4:0]] <= avs_writedata_in[7:0];
				end
			end else if (avs_read_in || avs_write_in) begin
				avs_waitrequest_out <= 1'b0;
				if (avs_address_in == `CSB_REG_CTRL)
					avs_readdata_out <= {28'h0000000, ctrl};
				else if (avs_address_in == `CSB_REG_STAT)
					avs_readdata_out <= {12'h000, op_ch, op_act, ctl_busy_in, ce_acc, pend_w};
				else if (s_hit)
					avs_readdata_out <= {24'h000000, sns_mem[s_word[4:0]]};
				else
					avs_readdata_out <= 32'h00000000;
			end
		end
	end
endmodule // csb_status

// ===== hdl/csb_map.vh
`ifndef CSB_MAP_VH
`define CSB_MAP_VH
// Behaviour
// - Show status while tagged, clear on acceptance.
// - Dual switch: status goes to starting channel.
// - Modifier with busy means controller busy.
// - Controller-free flag after busy-modifier or late checks.
// - Pending free flag refuses; other side short-busy.
// - Busy or free flag ends command chaining.
// - Busy only at initial selection.
// - Own drive status: busy unless Test I/O.
// - Busy while other interface attached or resetting.
// - Diagnostics running answer selections with short-busy.
// - Channel end once per operation.
// - Device end once per operation.
// - Shared drive ready: device end both channels.
// - Device end on completions and tape markers.
// - Device end after ready or busy attempt.
// - Device end on ready drop, except motion commands.
// - Event unit check only during operation activity; refusal and not-ready checks need none.
// - Unit check from sense bits, unload, start marker.
// - Repeated Test I/O on not-ready drive checks.
// - Retry mark with unit check; refusal checks.
// - Unit exception on file marker or end warning.
// - Sense command returns sense bytes, set reads 1.
// - Retry requested on dedicated mark line.

// Register byte offsets, sense window word base and word count.
`define CSB_REG_CTRL 8'h00
`define CSB_REG_STAT 8'h04
`define CSB_REG_SENSE 8'h40
`define CSB_SENSE_WBASE 6'h10
`define CSB_SENSE_CNT 6'd22
// Control register fields and reset value.
`define CSB_CTRL_DUAL 0
`define CSB_CTRL_BUFFERED 1
`define CSB_CTRL_ARMED 2
`define CSB_CTRL_DIAG 3
`define CSB_CTRL_RESET 4'h0
// Status byte bit masks, bit 0 is the most significant.
`define CSB_ST_MOD 8'h40
`define CSB_ST_FREE 8'h20
`define CSB_ST_BUSY 8'h10
`define CSB_ST_CE 8'h08
`define CSB_ST_DE 8'h04
`define CSB_ST_UC 8'h02
`define CSB_ST_UE 8'h01
`define CSB_ST_LEGAL 8'h7f
// Commands decoded at selection.
`define CSB_CMD_TIO 8'h00
`define CSB_CMD_NOP 8'h03
// Operation kinds from command execution.
`define CSB_KIND_READ 2'd0
`define CSB_KIND_WRITE 2'd1
`define CSB_KIND_CTRL 2'd2
`define CSB_KIND_MOTION 2'd3
`endif

// ===== verif/csb_status_assertions.sv
`timescale 1ns/1ns
module csb_status_assertions (
	input wire clk_in,
	input wire arst_n_in,
	input wire avs_read_in,
	input wire avs_write_in,
	input wire avs_waitrequest_out,
	input wire [1:0] chn_accept_in,
	input wire [15:0] chn_bus_out,
	input wire [1:0] chn_parity_out,
	input wire [1:0] chn_status_tag_out,
	input wire [1:0] chn_mark0_out,
	input wire [1:0] chn_short_busy_out
);
default clocking cb @(posedge clk_in);
endclocking
default disable iff (!arst_n_in);
a_modifier_needs_busy: assert property (chn_bus_out[6] |-> chn_bus_out[4])
	else $error("modifier shown without busy");
a_bit_zero_clear: assert property (!chn_bus_out[7] && !chn_bus_out[15])
	else $error("status bit zero set");
a_parity_odd: assert property (^{chn_bus_out[7:0], chn_parity_out[0]})
	else $error("bus parity not odd");
a_idle_bus_zero: assert property (!chn_status_tag_out[0] |-> chn_bus_out[7:0] == 8'h00)
	else $error("bus not zero without tag");
a_mark_with_check: assert property (chn_mark0_out[0] |-> chn_status_tag_out[0] && chn_bus_out[1])
	else $error("retry mark without unit check");
a_drop_after_accept: assert property ($rose(chn_accept_in[0]) && chn_status_tag_out[0]
	|-> ##[1:6] !chn_status_tag_out[0])
	else $error("status kept after accept");
a_short_busy_pulse: assert property (chn_short_busy_out[0] |=> !chn_short_busy_out[0])
	else $error("short busy longer than one cycle");
a_bus_answer: assert property ((avs_read_in || avs_write_in) && avs_waitrequest_out
	|=> !avs_waitrequest_out)
	else $error("bus request not answered");
c_status: cover property ($rose(chn_status_tag_out[0]));
c_short: cover property (chn_short_busy_out[0]);
c_retry: cover property (chn_mark0_out[0]);
endmodule // csb_status_assertions
bind csb_status csb_status_assertions u_csb_status_assertions (.clk_in, .arst_n_in,
	.avs_read_in, .avs_write_in, .avs_waitrequest_out, .chn_accept_in, .chn_bus_out,
	.chn_parity_out, .chn_status_tag_out, .chn_mark0_out, .chn_short_busy_out);

// ===== verif/csb_host_model.sv
`timescale 1ns/1ns
module csb_host_model (
	input wire clk_in,
	input wire arst_n_in,
	input wire slow_in,
	input wire [1:0] tag_in,
	output wire [1:0] accept_out,
	output wire [1:0] chain_out
);
// The channel never chains after busy or a controller-free flag.
assign chain_out = 2'b00;
genvar i;
for (i = 0; i < 2; i++) begin : g_ch
	reg [2:0] cnt;
	reg acc;
	assign accept_out[i] = acc;
	always @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			acc <= 1'b0;
			cnt <= 3'h0;
		end else if (!tag_in[i]) begin
			acc <= 1'b0;
			cnt <= 3'h0;
		end else if (cnt == (slow_in ? 3'h6 : 3'h1)) begin
			acc <= 1'b1;
		end else begin
			cnt <= cnt + 3'h1;
		end
	end
end
endmodule // csb_host_model

// ===== verif/testbench.sv
`timescale 1ns/1ns
`include "csb_map.vh"
module testbench;
logic clk_in = 1'b0, arst_n_in = 1'b0, avs_read_in = 1'b0, avs_write_in = 1'b0;
logic [7:0] avs_address_in = 8'h00;
logic [31:0] avs_writedata_in = 32'h0, q;
logic [1:0] chn_select_in = 2'b00, chn_reset_in = 2'b00, op_kind_in = 2'b00;
logic [7:0] chn_drive_in = 8'h11;
logic [15:0] chn_cmd_in = 16'h0101, drv_busy_in = 16'h0, drv_ready_in = 16'hffff;
logic op_start_in = 1'b0, ctl_busy_in = 1'b0, slow = 1'b0, op_chan = 1'b0;
logic [8:0] ev = 9'h0;
logic [4:0] sns_index_in = 5'h0;
wire [31:0] avs_readdata_out;
wire avs_waitrequest_out;
wire [15:0] chn_bus_out;
wire [1:0] chn_accept_in, chn_chain_in, chn_parity_out, chn_status_tag_out, chn_mark0_out;
wire [1:0] chn_short_busy_out;
wire [7:0] sns_byte_out;
int mismatches = 0, samples_checked = 0;
always #10 clk_in = ~clk_in;
csb_status u_csb_status (.clk_in, .arst_n_in, .avs_address_in, .avs_read_in, .avs_write_in,
	.avs_writedata_in, .avs_readdata_out, .avs_waitrequest_out, .chn_select_in, .chn_drive_in,
	.chn_cmd_in, .chn_accept_in, .chn_chain_in, .chn_reset_in, .chn_bus_out, .chn_parity_out,
	.chn_status_tag_out, .chn_mark0_out, .chn_short_busy_out, .op_start_in, .op_chan_in(op_chan),
	.op_drive_in(4'h1), .op_kind_in, .ctl_busy_in, .drv_busy_in, .drv_ready_in,
	.drv_shared_in(16'h0), .ev_data_done_in(ev[0]), .ev_ctl_accept_in(ev[1]),
	.ev_ctl_done_in(ev[2]), .ev_unload_done_in(ev[3]), .ev_marker_in(ev[4]),
	.ev_backward_start_in(ev[5]), .ev_file_marker_in(ev[6]), .ev_end_warning_in(ev[7]),
	.ev_retry_in(ev[8]), .sns_index_in, .sns_byte_out);
csb_host_model u_csb_host_model (.clk_in, .arst_n_in, .slow_in(slow), .tag_in(chn_status_tag_out),
	.accept_out(chn_accept_in), .chain_out(chn_chain_in));
task automatic check(input logic [31:0] got, input logic [31:0] exp);
	samples_checked++;
	if (got !== exp) begin
		mismatches++;
		$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
	end
endtask
task automatic avs(input logic wr, input logic [7:0] a, input logic [31:0] d);
	@(posedge clk_in);
	avs_address_in <= a;
	avs_writedata_in <= d;
	avs_write_in <= wr;
	avs_read_in <= !wr;
	do begin
		@(posedge clk_in);
	end while (avs_waitrequest_out !== 1'b0);
	q = avs_readdata_out;
	avs_write_in <= 1'b0;
	avs_read_in <= 1'b0;
endtask
task automatic fire(input int b);
	@(posedge clk_in);
	ev[b] <= 1'b1;
	@(posedge clk_in);
	ev <= 9'h0;
endtask
task automatic expect_status(input logic [8:0] exp);
	// A presentation that never comes or never ends is left to the watchdog.
	while (chn_status_tag_out[0] !== 1'b1) begin
		@(posedge clk_in);
	end
	check({23'h0, chn_mark0_out[0], chn_bus_out[7:0]}, {23'h0, exp});
	while (chn_status_tag_out[0] !== 1'b0) begin
		@(posedge clk_in);
	end
	repeat (4) @(posedge clk_in);
endtask
task automatic t_regs;
	avs(1'b0, `CSB_REG_CTRL, 32'h0);
	check(q, {28'h0, `CSB_CTRL_RESET});
	avs(1'b1, `CSB_REG_CTRL, 32'h5);
	avs(1'b0, `CSB_REG_CTRL, 32'h0);
	check(q, 32'h5);
	avs(1'b0, 8'h20, 32'h0);
	check(q, 32'h0);
	avs(1'b1, `CSB_REG_SENSE + 8'h0c, 32'h4c);
	avs(1'b1, `CSB_REG_CTRL, 32'h0);
	sns_index_in <= 5'h3;
	repeat (3) @(posedge clk_in);
	check({24'h0, sns_byte_out}, 32'h4c);
	$display("test regs done");
endtask
task automatic t_ops;
	int kd[8] = '{0, 0, 1, 3, 0, 0, 3, 2};
	int eb[8] = '{0, 6, 7, 3, 8, 5, 4, 1};
	logic [8:0] ex[8] = '{9'h00c, 9'h001, 9'h001, 9'h006, 9'h102, 9'h002, 9'h004, 9'h008};
	for (int i = 0; i < 8; i++) begin
		@(posedge clk_in);
		op_kind_in <= kd[i][1:0];
		op_start_in <= 1'b1;
		@(posedge clk_in);
		op_start_in <= 1'b0;
		fire(eb[i]);
		expect_status(ex[i]);
	end
	// Channel end is accepted; an exception while busy also owes a free flag.
	ctl_busy_in <= 1'b1;
	fire(6);
	expect_status(9'h021);
	ctl_busy_in <= 1'b0;
	$display("test ops done");
endtask
task automatic t_busy;
	slow <= 1'b1;
	ctl_busy_in <= 1'b1;
	@(posedge clk_in);
	chn_select_in <= 2'b01;
	expect_status(9'h050);
	chn_select_in <= 2'b00;
	ctl_busy_in <= 1'b0;
	expect_status(9'h020);
	drv_busy_in <= 16'h0002;
	@(posedge clk_in);
	chn_select_in <= 2'b01;
	expect_status(9'h010);
	chn_select_in <= 2'b00;
	drv_busy_in <= 16'h0;
	slow <= 1'b0;
	expect_status(9'h004);
	$display("test busy done");
endtask
task automatic t_diag;
	logic seen;
	seen = 1'b0;
	avs(1'b1, `CSB_REG_CTRL, 32'h8);
	repeat (2) @(posedge clk_in);
	chn_select_in <= 2'b01;
	repeat (20) begin
		@(posedge clk_in);
		seen = seen | chn_short_busy_out[0];
	end
	check({31'h0, seen}, 32'h1);
	chn_select_in <= 2'b00;
	avs(1'b1, `CSB_REG_CTRL, 32'h0);
	$display("test diag done");
endtask
task automatic t_chan_b;
	logic [1:0] seen;
	logic [7:0] got;
	seen = 2'b00;
	got = 8'h00;
	@(posedge clk_in);
	op_chan <= 1'b1;
	op_kind_in <= 2'd0;
	op_start_in <= 1'b1;
	@(posedge clk_in);
	op_start_in <= 1'b0;
	fire(0);
	repeat (14) begin
		@(posedge clk_in);
		seen = seen | chn_status_tag_out;
		got = got | chn_bus_out[15:8];
	end
	check({22'h0, seen, got}, {22'h0, 2'b10, 8'h0c});
	$display("test channel b done");
endtask
task automatic complete_run;
	$display("checks=%0d mismatches=%0d", samples_checked, mismatches);
	if (mismatches == 0 && samples_checked > 0)
		$display("RESULT: PASS");
	else
		$display("RESULT: FAIL");
	$finish;
endtask
initial begin
	repeat (8) @(posedge clk_in);
	arst_n_in <= 1'b1;
	repeat (4) @(posedge clk_in);
	t_regs;
	t_ops;
	t_busy;
	t_diag;
	t_chan_b;
	complete_run;
end
initial begin
	#100000;
	mismatches++;
	complete_run;
end
endmodule // testbench
